// ### rtl/tfp_touch_ctrl.sv
// register port, save control, sample filters and gpio pwm of the touch controller
//
// Function
// - critical registers acknowledged within 140 us
// - save command acknowledged within 100 us
// - nothing else accepted until save completes
// - optional averaging over 2,4,8,16 samples
// - drop samples whose scan saw traffic
// - pwm may be routed onto gpio pins
// - fifteen selectable pwm duty settings
// - modes normal, single, delayed, toggle
// - pwm settings at registers 18h-1Bh
`timescale 1ns/10ps
`default_nettype none
module tfp_touch_ctrl #(
   parameter int NUM_GPIO = 8,
   parameter int COUNT_W = 16,
   parameter int BOOT_CYCLES = tfp_pkg::BOOT_CYC,
   parameter int CRIT_ACK_MAX = tfp_pkg::ACK_CRIT_MAX_CYC,
   parameter int SAVE_ACK_MAX = tfp_pkg::ACK_SAVE_MAX_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // register port from the serial slave front end
   input wire logic reqValid,
   input wire tfp_pkg::regReq_s req,
   output tfp_pkg::regRsp_s rsp,
   output logic portReady,
   // nonvolatile store
   output logic nvmSaveStart,
   input wire logic nvmSaveDone,
   // sensing core
   input wire logic scanStart,
   input wire logic rawValid,
   input wire logic [COUNT_W-1:0] rawCount,
   output logic filtValid,
   output logic [COUNT_W-1:0] filtCount,
   // general purpose pins
   input wire logic [NUM_GPIO-1:0] gpioIn,
   output logic [NUM_GPIO-1:0] gpioOut
);
   localparam int SUM_W = COUNT_W + 4;

   initial begin
      if (NUM_GPIO < 1 || NUM_GPIO > 8) $error("tfp_touch_ctrl: NUM_GPIO must be 1..8");
      if (COUNT_W < 8 || COUNT_W > 16) $error("tfp_touch_ctrl: COUNT_W must be 8..16");
      if (BOOT_CYCLES < 1) $error("tfp_touch_ctrl: BOOT_CYCLES must be positive");
      if (CRIT_ACK_MAX < tfp_pkg::ACK_LATENCY_CYC) $error("tfp_touch_ctrl: ack limit too short");
      if (SAVE_ACK_MAX < tfp_pkg::ACK_LATENCY_CYC) $error("tfp_touch_ctrl: save ack limit too short");
   end

   // number of samples in the window, as a shift amount
   function automatic logic [2:0] depthShift(input logic [1:0] code);
      depthShift = {1'b0, code} + 3'h1;
   endfunction

   // ****************************************
   // control state: boot, ready, save
   // ****************************************
   tfp_pkg::ctlState_e state_q, state_d;
   logic [$clog2(BOOT_CYCLES+1)-1:0] bootCnt_q;
   logic bootDone;
   logic take;
   logic isSave;

   assign bootDone = (bootCnt_q == ($clog2(BOOT_CYCLES+1))'(BOOT_CYCLES));
   // requests arriving during boot or an unfinished save are not taken
   assign portReady = (state_q == tfp_pkg::CTL_READY);
   assign take = reqValid && portReady;
   assign isSave = take && req.wr && req.addr == tfp_pkg::ADDR_COMMAND && req.data == tfp_pkg::CMD_SAVE;

   // next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         tfp_pkg::CTL_BOOT: begin
            if (bootDone) state_d = tfp_pkg::CTL_READY;
         end
         tfp_pkg::CTL_READY: begin
            if (isSave) state_d = tfp_pkg::CTL_SAVE;
         end
         tfp_pkg::CTL_SAVE: begin
            if (nvmSaveDone) state_d = tfp_pkg::CTL_READY;
         end
         default: state_d = tfp_pkg::CTL_BOOT;
      endcase
   end

   // state and boot timer
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= tfp_pkg::CTL_BOOT;
         bootCnt_q <= '0;
      end else begin
         state_q <= state_d;
         if (!bootDone) bootCnt_q <= bootCnt_q + 1'b1;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   logic [7:0] outReg_q, sense_q, pwmA_q, pwmB_q, pwmC_q, pwmD_q;
   logic dropped_q;
   logic avgFull;
   logic [7:0] gpioInByte, countHi, countLo, statusByte;
   logic [7:0] rdMux;
   logic wrOutput, wrSense, wrPwmA, wrPwmB, wrPwmC, wrPwmD;

   assign wrOutput = take && req.wr && req.addr == tfp_pkg::ADDR_OUTPUT;
   assign wrSense = take && req.wr && req.addr == tfp_pkg::ADDR_SENSE;
   assign wrPwmA = take && req.wr && req.addr == tfp_pkg::ADDR_PWM_A;
   assign wrPwmB = take && req.wr && req.addr == tfp_pkg::ADDR_PWM_B;
   assign wrPwmC = take && req.wr && req.addr == tfp_pkg::ADDR_PWM_C;
   assign wrPwmD = take && req.wr && req.addr == tfp_pkg::ADDR_PWM_D;

   assign gpioInByte = 8'(gpioIn);
   assign countLo = filtCount[7:0];
   assign countHi = 8'(filtCount[COUNT_W-1:8]);
   assign statusByte = {4'h0, dropped_q, avgFull, bootDone, state_q == tfp_pkg::CTL_SAVE};

   // read selection; unmapped addresses read as zero
   assign rdMux = (req.addr == tfp_pkg::ADDR_INPUT) ? gpioInByte :
                  (req.addr == tfp_pkg::ADDR_OUTPUT) ? outReg_q :
                  (req.addr == tfp_pkg::ADDR_SENSE) ? sense_q :
                  (req.addr == tfp_pkg::ADDR_COUNT_LO) ? countLo :
                  (req.addr == tfp_pkg::ADDR_COUNT_HI) ? countHi :
                  (req.addr == tfp_pkg::ADDR_STATUS) ? statusByte :
                  (req.addr == tfp_pkg::ADDR_PWM_A) ? pwmA_q :
                  (req.addr == tfp_pkg::ADDR_PWM_B) ? pwmB_q :
                  (req.addr == tfp_pkg::ADDR_PWM_C) ? pwmC_q :
                  (req.addr == tfp_pkg::ADDR_PWM_D) ? pwmD_q : 8'h00;

   // every taken access, save included, is answered on the next edge
   always_ff @(posedge clock) begin
      if (rst) begin
         rsp <= '0;
      end else begin
         rsp.ack <= take;
         rsp.data <= (take && !req.wr) ? rdMux : rsp.data;
      end
   end

   // one start pulse towards the store per save command
   always_ff @(posedge clock) begin
      if (rst) nvmSaveStart <= 1'b0;
      else nvmSaveStart <= isSave;
   end

   // writable registers
   always_ff @(posedge clock) begin
      if (rst) begin
         outReg_q <= tfp_pkg::RST_OUTPUT;
         sense_q <= tfp_pkg::RST_SENSE;
         pwmA_q <= tfp_pkg::RST_PWM_A;
         pwmB_q <= tfp_pkg::RST_PWM_B;
         pwmC_q <= tfp_pkg::RST_PWM_C;
         pwmD_q <= tfp_pkg::RST_PWM_D;
      end else begin
         if (wrOutput) outReg_q <= req.data;
         if (wrSense) sense_q <= req.data;
         if (wrPwmA) pwmA_q <= req.data;
         if (wrPwmB) pwmB_q <= req.data;
         if (wrPwmC) pwmC_q <= req.data;
         if (wrPwmD) pwmD_q <= req.data;
      end
   end

   // ****************************************
   // drop-sample filter
   // ****************************************
   logic scanning_q, dirty_q, inScan, accept;

   assign inScan = scanning_q || scanStart;
   assign accept = rawValid && !(sense_q[tfp_pkg::SENSE_DROP_EN] && (dirty_q || take));

   // traffic seen while a scan runs marks its sample; a new start wins over the end
   always_ff @(posedge clock) begin
      if (rst) begin
         scanning_q <= 1'b0;
         dirty_q <= 1'b0;
         dropped_q <= 1'b0;
      end else begin
         scanning_q <= scanStart || (scanning_q && !rawValid);
         dirty_q <= (take && inScan && !rawValid) || (scanStart && take) ||
                    (dirty_q && !rawValid && !scanStart);
         if (rawValid) dropped_q <= !accept;
      end
   end

   // ****************************************
   // averaging filter
   // ****************************************
   logic avgEn;
   logic [2:0] shift;
   logic [4:0] depthN, fill_q;
   logic [3:0] wp_q, rdAddr;
   logic [COUNT_W-1:0] new_q, oldRd, oldVal;
   logic stage1_q;
   logic [SUM_W-1:0] sum_q, sumNext;

   assign avgEn = sense_q[tfp_pkg::SENSE_AVG_EN];
   assign shift = depthShift(sense_q[tfp_pkg::SENSE_DEPTH_LSB +: 2]);
   assign depthN = 5'h01 << shift;
   assign rdAddr = wp_q - 4'(depthN);
   assign avgFull = (fill_q == depthN);
   assign oldVal = avgFull ? oldRd : '0;
   assign sumNext = sum_q + SUM_W'(new_q) - SUM_W'(oldVal);

   tfp_sample_mem #(
      .WIDTH(COUNT_W),
      .DEPTH(16)
   ) u_window (
      .clock(clock),
      .wrEn(stage1_q),
      .wrAddr(wp_q),
      .wrData(new_q),
      .rdAddr(rdAddr),
      .rdData(oldRd)
   );

   // window bookkeeping; changing depth or enable restarts the window
   always_ff @(posedge clock) begin
      if (rst || wrSense) begin
         stage1_q <= 1'b0;
         new_q <= '0;
         wp_q <= '0;
         fill_q <= '0;
         sum_q <= '0;
      end else begin
         stage1_q <= accept && avgEn;
         if (accept) new_q <= rawCount;
         if (stage1_q) begin
            sum_q <= sumNext;
            wp_q <= wp_q + 4'h1;
            if (!avgFull) fill_q <= fill_q + 5'h01;
         end
      end
   end

   // result: averaged window, or the raw count when the filter is off
   always_ff @(posedge clock) begin
      if (rst) begin
         filtValid <= 1'b0;
         filtCount <= '0;
      end else begin
         filtValid <= (accept && !avgEn) || stage1_q;
         if (accept && !avgEn) filtCount <= rawCount;
         else if (stage1_q) filtCount <= COUNT_W'(sumNext >> shift);
      end
   end

   // ****************************************
   // pwm generator
   // ****************************************
   tfp_pkg::pwmMode_e mode;
   logic [3:0] target, level_q, phase_q;
   logic [7:0] pre_q;
   logic tick, periodEnd, cmp, armed_q, running_q, tff_q, pwm_d, pwm_q;

   assign mode = tfp_pkg::pwmMode_e'(pwmB_q[1:0]);
   // codes above the top setting clamp, leaving fifteen distinct levels
   assign target = (pwmA_q[3:0] > tfp_pkg::DUTY_MAX) ? tfp_pkg::DUTY_MAX : pwmA_q[3:0];
   // at or above the limit, so lowering the prescale mid-count cannot stall for a full wrap
   assign tick = (pre_q >= pwmD_q);
   assign periodEnd = tick && (phase_q == tfp_pkg::PHASE_LAST);
   assign cmp = (phase_q <= level_q);

   // output per mode
   always_comb begin
      unique case (mode)
         tfp_pkg::PWM_NORMAL: pwm_d = cmp;
         tfp_pkg::PWM_SINGLE: pwm_d = running_q && cmp;
         tfp_pkg::PWM_DELAYED: pwm_d = cmp;
         tfp_pkg::PWM_TOGGLE: pwm_d = tff_q;
      endcase
   end

   // prescaler and fifteen-step phase
   always_ff @(posedge clock) begin
      if (rst) begin
         pre_q <= 8'h00;
         phase_q <= 4'h0;
      end else begin
         pre_q <= tick ? 8'h00 : pre_q + 8'h01;
         if (tick) phase_q <= (phase_q == tfp_pkg::PHASE_LAST) ? 4'h0 : phase_q + 4'h1;
      end
   end

   // level tracking, single-pulse arming and toggle flop
   always_ff @(posedge clock) begin
      if (rst) begin
         level_q <= 4'h0;
         armed_q <= 1'b0;
         running_q <= 1'b0;
         tff_q <= 1'b0;
         pwm_q <= 1'b0;
      end else begin
         // delayed transition walks one step per period so leds fade
         if (mode != tfp_pkg::PWM_DELAYED) level_q <= target;
         else if (periodEnd && level_q < target) level_q <= level_q + 4'h1;
         else if (periodEnd && level_q > target) level_q <= level_q - 4'h1;
         // a write of the mode register arms one pulse at the next period
         if (wrPwmB) armed_q <= 1'b1;
         else if (periodEnd) armed_q <= 1'b0;
         if (periodEnd) running_q <= armed_q && mode == tfp_pkg::PWM_SINGLE;
         if (tick && phase_q == level_q) tff_q <= !tff_q;
         pwm_q <= pwm_d;
      end
   end

   // ****************************************
   // gpio output routing
   // ****************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         gpioOut <= '0;
      end else begin
         for (int i = 0; i < NUM_GPIO; i++) begin
            gpioOut[i] <= pwmC_q[i] ? pwm_q : outReg_q[i];
         end
      end
   end
endmodule // tfp_touch_ctrl
`default_nettype wire

// ### pkg/tfp_pkg.sv
// constants, register map and carrier types for the touch filter / pwm block
package tfp_pkg;
   // ****************************************
   // register map (byte offsets on the serial register port)
   // ****************************************
   localparam logic [7:0] ADDR_INPUT = 8'h00;
   localparam logic [7:0] ADDR_OUTPUT = 8'h04;
   localparam logic [7:0] ADDR_SENSE = 8'h08;
   localparam logic [7:0] ADDR_COUNT_LO = 8'h0C;
   localparam logic [7:0] ADDR_COUNT_HI = 8'h0D;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_PWM_A = 8'h18;
   localparam logic [7:0] ADDR_PWM_B = 8'h19;
   localparam logic [7:0] ADDR_PWM_C = 8'h1A;
   localparam logic [7:0] ADDR_PWM_D = 8'h1B;
   localparam logic [7:0] ADDR_COMMAND = 8'hA0;
   localparam logic [7:0] CMD_SAVE = 8'h01;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int SENSE_AVG_EN = 0;
   localparam int SENSE_DEPTH_LSB = 1;
   localparam int SENSE_DROP_EN = 3;
   localparam int STAT_SAVE_BUSY = 0;
   localparam int STAT_BOOTED = 1;
   localparam int STAT_AVG_FULL = 2;
   localparam int STAT_DROPPED = 3;
   localparam logic [7:0] RST_OUTPUT = 8'h00;
   localparam logic [7:0] RST_SENSE = 8'h00;
   localparam logic [7:0] RST_PWM_A = 8'h00;
   localparam logic [7:0] RST_PWM_B = 8'h00;
   localparam logic [7:0] RST_PWM_C = 8'h00;
   localparam logic [7:0] RST_PWM_D = 8'h00;
   localparam logic [3:0] DUTY_MAX = 4'hE;
   localparam logic [3:0] PHASE_LAST = 4'hE;

   // ****************************************
   // timing (clock 40 MHz, 25 ns)
   // ****************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int ACK_CRIT_MAX_US = 140;
   localparam int ACK_SAVE_MAX_US = 100;
   localparam int BOOT_TIME_US = 100;
   localparam int ACK_CRIT_MAX_CYC = (ACK_CRIT_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int ACK_SAVE_MAX_CYC = (ACK_SAVE_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int BOOT_CYC = (BOOT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACK_LATENCY_CYC = 1;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      PWM_NORMAL = 2'h0,
      PWM_SINGLE = 2'h1,
      PWM_DELAYED = 2'h2,
      PWM_TOGGLE = 2'h3
   } pwmMode_e;

   typedef enum logic [1:0] {
      CTL_BOOT = 2'h0,
      CTL_READY = 2'h1,
      CTL_SAVE = 2'h3
   } ctlState_e;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } regReq_s;

   typedef struct packed {
      logic ack;
      logic [7:0] data;
   } regRsp_s;
endpackage

// ### rtl/tfp_sample_mem.sv
// small sample memory for the averaging window, registered read
`timescale 1ns/10ps
`default_nettype none
module tfp_sample_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // clock
   input wire logic clock,
   // write side
   input wire logic wrEn,
   input wire logic [$clog2(DEPTH)-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   // read side
   input wire logic [$clog2(DEPTH)-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);
   logic [WIDTH-1:0] mem [DEPTH];

   initial begin
      if (DEPTH < 2 || WIDTH < 1) $error("tfp_sample_mem: bad size");
   end

   // ****************************************
   // storage
   // ****************************************
   // no reset on the array: unwritten words are masked by the fill count
   always_ff @(posedge clock) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule // tfp_sample_mem
`default_nettype wire

// ### test/tfp_touch_ctrl_monitor.sv
// port-level assertion checker for the touch controller
`timescale 1ns/10ps
`default_nettype none
module tfp_touch_ctrl_monitor #(
   parameter int NUM_GPIO = 8,
   parameter int COUNT_W = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // register port
   input wire logic reqValid,
   input wire tfp_pkg::regReq_s req,
   input wire tfp_pkg::regRsp_s rsp,
   input wire logic portReady,
   // nonvolatile store
   input wire logic nvmSaveStart,
   input wire logic nvmSaveDone,
   // sensing core
   input wire logic scanStart,
   input wire logic rawValid,
   input wire logic [COUNT_W-1:0] rawCount,
   input wire logic filtValid,
   input wire logic [COUNT_W-1:0] filtCount,
   // pins
   input wire logic [NUM_GPIO-1:0] gpioIn,
   input wire logic [NUM_GPIO-1:0] gpioOut
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ****************************************
   // shadow of sense register, scan traffic and save phase
   // ****************************************
   logic [7:0] sense_q;
   logic scan_q;
   logic dirty_q;
   logic saving_q;
   // decoded events seen on the register port
   wire logic take = reqValid && portReady;
   wire logic senseWr = take && req.wr && (req.addr == tfp_pkg::ADDR_SENSE);
   wire logic saveWr = take && req.wr && (req.addr == tfp_pkg::ADDR_COMMAND) && (req.data == tfp_pkg::CMD_SAVE);
   wire logic dropNow = rawValid && sense_q[3] && (dirty_q || take);
   // traffic counts from scan start up to and including the result cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         sense_q <= tfp_pkg::RST_SENSE;
         scan_q <= 1'b0;
         dirty_q <= 1'b0;
         saving_q <= 1'b0;
      end else begin
         if (senseWr) begin
            sense_q <= req.data;
         end
         scan_q <= scanStart || (scan_q && !rawValid);
         dirty_q <= (scanStart && take) || (!rawValid && !scanStart && scan_q && (dirty_q || take));
         saving_q <= nvmSaveStart || (saving_q && !nvmSaveDone);
      end
   end
   AST_ACK_TAKEN: assert property (take |=> rsp.ack)
      else $error("taken request got no ack next cycle");
   AST_ACK_CAUSE: assert property (rsp.ack |-> $past(take))
      else $error("ack without a taken request");
   AST_SAVE_START: assert property (saveWr |=> nvmSaveStart && rsp.ack && !portReady)
      else $error("save command did not start store");
   AST_START_CAUSE: assert property (nvmSaveStart |-> $past(saveWr))
      else $error("store started without save command");
   AST_SAVE_BUSY: assert property (saving_q |-> !portReady)
      else $error("port ready while store in progress");
   AST_RAW_PASS: assert property (rawValid && !sense_q[0] && !dropNow |=> filtValid && filtCount == $past(rawCount))
      else $error("raw count not passed through");
   AST_AVG_LAT: assert property (rawValid && sense_q[0] && !dropNow |-> ##2 filtValid)
      else $error("averaged result late or missing");
   AST_DROP: assert property (dropNow |=> !filtValid [*2])
      else $error("disturbed sample not dropped");
   AST_FILT_CAUSE: assert property (filtValid |-> $past(rawValid) || $past(rawValid, 2))
      else $error("result without a sample");
endmodule // tfp_touch_ctrl_monitor
bind tfp_touch_ctrl tfp_touch_ctrl_monitor #(.NUM_GPIO(NUM_GPIO), .COUNT_W(COUNT_W)) tfp_touch_ctrl_monitor_inst (
   .clock(clock), .rst(rst), .reqValid(reqValid), .req(req), .rsp(rsp), .portReady(portReady),
   .nvmSaveStart(nvmSaveStart), .nvmSaveDone(nvmSaveDone), .scanStart(scanStart), .rawValid(rawValid),
   .rawCount(rawCount), .filtValid(filtValid), .filtCount(filtCount), .gpioIn(gpioIn), .gpioOut(gpioOut)
);
`default_nettype wire

// ### test/tfp_host_model.sv
// host-side register port model for the touch controller bench
`timescale 1ns/10ps
`default_nettype none
module tfp_host_model (
   // clock
   input wire logic clock,
   // register port
   input wire logic portReady,
   input wire tfp_pkg::regRsp_s rsp,
   output var logic reqValid,
   output var tfp_pkg::regReq_s req
);
   // ****************************************
   // one register access per call
   // ****************************************
   // idle port at time zero
   initial begin
      reqValid = 1'b0;
      req = '0;
   end
   // rude skips the ready wait; the request is offered for one edge only
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data, input bit rude,
      output logic ackSeen, output logic [7:0] rdData);
      int n;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (!rude && portReady !== 1'b1 && n < 20000);
      @(posedge clock);
      reqValid <= 1'b1;
      req <= '{wr: wr, addr: addr, data: data};
      @(posedge clock);
      reqValid <= 1'b0;
      // released lines show garbage so stale values cannot pass
      req <= '{wr: ~wr, addr: ~addr, data: ~data};
      @(negedge clock);
      ackSeen = rsp.ack;
      rdData = rsp.data;
   endtask
endmodule // tfp_host_model
`default_nettype wire

// ### test/touch_filter_pwm_i2c_timing_bench.sv
// self-checking bench for the touch filter / pwm block
`timescale 1ns/10ps
`default_nettype none
module touch_filter_pwm_i2c_timing_bench;
   localparam int BOOT = 10;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic scanStart = 1'b0;
   logic rawValid = 1'b0;
   logic [15:0] rawCount = 16'h0000;
   logic [7:0] gpioIn = 8'h00;
   logic nvmSaveDone = 1'b0;
   logic reqValid;
   tfp_pkg::regReq_s req;
   tfp_pkg::regRsp_s rsp;
   logic portReady;
   logic nvmSaveStart;
   logic filtValid;
   logic [15:0] filtCount;
   logic [7:0] gpioOut;
   logic ack;
   logic [7:0] rd;
   int duties [4] = '{0, 7, 14, 15};
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   // 40 MHz clock
   always #12.5 clock = ~clock;
   tfp_touch_ctrl #(.BOOT_CYCLES(BOOT)) tfp_touch_ctrl_inst (
      .clock(clock), .rst(rst), .reqValid(reqValid), .req(req), .rsp(rsp), .portReady(portReady),
      .nvmSaveStart(nvmSaveStart), .nvmSaveDone(nvmSaveDone), .scanStart(scanStart), .rawValid(rawValid),
      .rawCount(rawCount), .filtValid(filtValid), .filtCount(filtCount), .gpioIn(gpioIn), .gpioOut(gpioOut)
   );
   tfp_host_model tfp_host_model_inst (
      .clock(clock), .portReady(portReady), .rsp(rsp), .reqValid(reqValid), .req(req)
   );
   // ****************************************
   // comparison, verdict and access helpers
   // ****************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic wrReg(input logic [7:0] addr, input logic [7:0] data);
      tfp_host_model_inst.access(1'b1, addr, data, 1'b0, ack, rd);
      check("write ack", ack, 1'b1);
   endtask
   task automatic rdReg(input logic [7:0] addr, input logic [7:0] exp, input string what);
      tfp_host_model_inst.access(1'b0, addr, 8'h00, 1'b0, ack, rd);
      check("read ack", ack, 1'b1);
      check(what, rd, exp);
   endtask
   // one scan; dirty puts a register read in the middle of it
   task automatic sample(input logic [15:0] v, input bit dirty, output logic got, output logic [15:0] val);
      @(posedge clock) scanStart <= 1'b1;
      @(posedge clock) scanStart <= 1'b0;
      if (dirty) rdReg(tfp_pkg::ADDR_INPUT, gpioIn, "input reg");
      @(posedge clock) rawValid <= 1'b1;
      rawCount <= v;
      @(posedge clock) rawValid <= 1'b0;
      rawCount <= ~v;
      got = 1'b0;
      repeat (3) begin
         @(negedge clock);
         if (filtValid === 1'b1 && !got) begin
            got = 1'b1;
            val = filtCount;
         end
      end
   endtask
   // high cycles of a routed pin over whole periods, duty clamps at the top setting
   function automatic int pwmHigh(input int duty, input int periods);
      return ((duty > int'(tfp_pkg::DUTY_MAX)) ? 15 : duty + 1) * periods;
   endfunction
   // hang guard, far above the expected run length
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         complete_run();
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic got;
      logic [15:0] v;
      logic [15:0] fv;
      int sum;
      int hi;
      void'($urandom(32'h3D8E));
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      gpioIn <= 8'($urandom);
      @(negedge clock);
      check("ready in boot", portReady, 1'b0);
      check("gpio after reset", gpioOut, 8'h00);
      for (int i = 0; i < 4; i++) rdReg(tfp_pkg::ADDR_PWM_A + 8'(i), 8'h00, "pwm reset");
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom);
         wrReg(tfp_pkg::ADDR_PWM_A + 8'(i), v[7:0]);
         rdReg(tfp_pkg::ADDR_PWM_A + 8'(i), v[7:0], "pwm readback");
      end
      rdReg(8'h30, 8'h00, "unmapped read");
      // filter off, then drop filter
      wrReg(tfp_pkg::ADDR_SENSE, 8'h00);
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 16'hFFFF : 16'($urandom);
         sample(v, 1'b0, got, fv);
         check("raw result", {got, fv}, {1'b1, v});
      end
      rdReg(tfp_pkg::ADDR_COUNT_LO, v[7:0], "count low");
      rdReg(tfp_pkg::ADDR_COUNT_HI, v[15:8], "count high");
      wrReg(tfp_pkg::ADDR_SENSE, 8'h08);
      sample(16'($urandom), 1'b1, got, fv);
      check("dropped sample", got, 1'b0);
      rdReg(tfp_pkg::ADDR_STATUS, 8'((1 << tfp_pkg::STAT_DROPPED) | (1 << tfp_pkg::STAT_BOOTED)), "status");
      v = 16'($urandom);
      sample(v, 1'b0, got, fv);
      check("clean sample", {got, fv}, {1'b1, v});
      // every averaging depth, window filled once
      for (int k = 0; k < 4; k++) begin
         wrReg(tfp_pkg::ADDR_SENSE, 8'((k << 1) | 1));
         sum = 0;
         for (int j = 0; j < (2 << k); j++) begin
            v = 16'($urandom);
            sum += v;
            sample(v, 1'b0, got, fv);
         end
         check("average", {got, fv}, {1'b1, 16'(sum >> (k + 1))});
      end
      // pwm duties on pin 0, plain output bits on the rest
      wrReg(tfp_pkg::ADDR_OUTPUT, 8'hA5);
      wrReg(tfp_pkg::ADDR_PWM_B, 8'(tfp_pkg::PWM_NORMAL));
      wrReg(tfp_pkg::ADDR_PWM_D, 8'h00);
      wrReg(tfp_pkg::ADDR_PWM_C, 8'h01);
      foreach (duties[i]) begin
         wrReg(tfp_pkg::ADDR_PWM_A, 8'(duties[i]));
         repeat (40) @(negedge clock);
         hi = 0;
         repeat (150) begin
            @(negedge clock);
            hi += int'(gpioOut[0]);
         end
         check("pwm high cycles", hi, pwmHigh(duties[i], 10));
      end
      check("plain gpio bits", gpioOut[7:1], 7'h52);
      // single pulse armed just after a falling edge, so the low phase hides stale output
      wrReg(tfp_pkg::ADDR_PWM_D, 8'h03);
      wrReg(tfp_pkg::ADDR_PWM_A, 8'h04);
      hi = 0;
      // low, high, low: the last fall opens a full low phase even if the duty change cut one short
      for (int w = 0; w < 3; w++) begin
         while (gpioOut[0] !== 1'(w % 2) && hi < 600) begin
            @(negedge clock);
            hi++;
         end
      end
      wrReg(tfp_pkg::ADDR_PWM_B, 8'(tfp_pkg::PWM_SINGLE));
      hi = 0;
      repeat (300) begin
         @(negedge clock);
         hi += int'(gpioOut[0]);
      end
      check("single pulse", hi, pwmHigh(4, 1) * 4);
      for (int m = 2; m < 4; m++) begin
         wrReg(tfp_pkg::ADDR_PWM_B, 8'(m));
         rdReg(tfp_pkg::ADDR_PWM_B, 8'(m), "pwm mode");
      end
      // toggle flips once per 60-cycle period at prescale 3, so any 240 cycles hold 120 high
      hi = 0;
      repeat (240) begin
         @(negedge clock);
         hi += int'(gpioOut[0]);
      end
      check("toggle high cycles", hi, 4 * 15 * 2);
      // save, then a refused write while the store is busy
      wrReg(tfp_pkg::ADDR_COMMAND, tfp_pkg::CMD_SAVE);
      tfp_host_model_inst.access(1'b1, tfp_pkg::ADDR_PWM_A, 8'h09, 1'b1, ack, rd);
      check("ack while saving", ack, 1'b0);
      repeat (8) @(posedge clock);
      nvmSaveDone <= 1'b1;
      @(posedge clock);
      nvmSaveDone <= 1'b0;
      rdReg(tfp_pkg::ADDR_PWM_A, 8'h04, "duty after save");
      complete_run();
   end
endmodule // touch_filter_pwm_i2c_timing_bench
`default_nettype wire
